// ===== rtl/shn_defs.svh
// shunt decimator constants: offsets, field positions, reset values
// Behaviour
// - each channel filters its bitstream with sinc3
// - one result per ratio modulator samples
// - three-bit field selects ratio 64 to 8192
// - ratios are eight powers of two
// - modulator rate is clock divided by two
// - subtract offset, then multiply by gain
// - round to 24 bits and saturate
// - 24-bit offset split over high/low registers
// - positive offset lowers output, negative raises
// - gain factor is one plus value/65536
// - host rewrites coefficients after every reset
// - host clears offset and gain before calibrating
// - host averages shorted-input results for offset
// - host averages sub-full-scale results for gain
// - results go out each frame unless read data
// - results are two's complement
// - clip at 800000h and 7FFFFFh
`ifndef SHN_DEFS_SVH
`define SHN_DEFS_SVH
`define SHN_ADR_RATIO 4'h0
`define SHN_ADR_CH_BASE 4'h1
`define SHN_ADR_CH_STRIDE 4'h3
`define SHN_OFS_HIGH 2'h0
`define SHN_OFS_LOW 2'h1
`define SHN_GAIN 2'h2
`define SHN_RATIO_B_LSB 4
`define SHN_RATIO_RST 3'h0
`define SHN_OFS_RST 24'h000000
`define SHN_GAIN_RST 16'h0000
`define SHN_RATIO_LOG_MIN 6
`define SHN_RATIO_CODE_MAX 3'h7
`define SHN_GAIN_ONE 18'h10000
`define SHN_ROUND_HALF 44'h00000008000
`define SHN_POS_FS 24'h7FFFFF
`define SHN_NEG_FS 24'h800000
`define SHN_N_REGS 7
`endif

// ===== rtl/shn_pkg.sv
// types shared by both ends of the shunt link
package shn_pkg;
  typedef logic signed [23:0] shn_code_t;
  typedef enum logic [1:0] {HS_IDLE, HS_SEQ} shn_host_st_t;
endpackage : shn_pkg

// ===== rtl/shn_link_if.sv
// link between converter back end and host
`timescale 1ns/10ps
interface shn_link_if;
  logic cmd_valid;
  logic cmd_ready;
  logic cmd_write;
  logic [3:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic frm_valid;
  logic frm_ready;
  logic frm_reg;
  logic [47:0] frm_data;
  modport dev (input cmd_valid, cmd_write, cmd_addr, cmd_wdata, frm_ready,
    output cmd_ready, frm_valid, frm_reg, frm_data);
  modport host (output cmd_valid, cmd_write, cmd_addr, cmd_wdata, frm_ready,
    input cmd_ready, frm_valid, frm_reg, frm_data);
endinterface : shn_link_if

// ===== rtl/shn_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module shn_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  assign in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule : shn_fifo

// ===== rtl/shn_dev.sv
// converter back end: sinc3 decimators, calibration, result framing
`timescale 1ns/10ps
`include "shn_defs.svh"
module shn_dev import shn_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // modulator side
  input wire logic [1:0] mod_bit_i,
  output logic mod_clk_o,
  output logic mod_en_o,
  // status
  output logic overrun_o,
  // link to host
  shn_link_if.dev lnk
);
  localparam int AW = 41;
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fifo too shallow");
  end

  function automatic logic [12:0] ratio_last(input logic [2:0] n);
    ratio_last = 13'((14'h1 << (`SHN_RATIO_LOG_MIN + n)) - 14'h1);
  endfunction : ratio_last

  // fullscale of OVERSAMPLING_RATIO^3 brought to 2^23; 25 bits keep the overshoot for clipping
  function automatic logic signed [24:0] norm(input logic signed [AW-1:0] v,
      input logic [2:0] n);
    logic signed [AW-1:0] t;
    t = v <<< (6'd21 - 6'(3 * n));
    norm = t[AW-1:16];
  endfunction : norm

  function automatic shn_code_t sat24(input logic signed [27:0] v);
    if (v > 28'sh07FFFFF) sat24 = `SHN_POS_FS;
    else if (v < -28'sh0800000) sat24 = `SHN_NEG_FS;
    else sat24 = v[23:0];
  endfunction : sat24

  ////////////////////////////////////////////////////////////////////////////
  // modulator clock
  logic mod_ph_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) mod_ph_q <= 1'b0;
    else mod_ph_q <= ~mod_ph_q;
  end
  assign mod_clk_o = mod_ph_q;
  assign mod_en_o = mod_ph_q;

  ////////////////////////////////////////////////////////////////////////////
  // coefficient registers, volatile: cleared by every reset
  logic [2:0] ratio_q [2];
  logic [23:0] ofs_q [2];
  logic [15:0] gain_q [2];
  logic rd_pend_q;
  logic [15:0] rd_data_q;
  logic cmd_take;
  logic [15:0] rd_mux;
  assign lnk.cmd_ready = !rd_pend_q;
  assign cmd_take = lnk.cmd_valid && lnk.cmd_ready;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ratio_q[0] <= `SHN_RATIO_RST;
      ratio_q[1] <= `SHN_RATIO_RST;
    end else if (cmd_take && lnk.cmd_write && lnk.cmd_addr == `SHN_ADR_RATIO) begin
      ratio_q[0] <= lnk.cmd_wdata[2:0];
      ratio_q[1] <= lnk.cmd_wdata[`SHN_RATIO_B_LSB +: 3];
    end
  end

  always_comb begin
    rd_mux = '0;
    if (lnk.cmd_addr == `SHN_ADR_RATIO) begin
      rd_mux = {9'h000, ratio_q[1], 1'b0, ratio_q[0]};
    end
    for (int c = 0; c < 2; c++) begin
      if (lnk.cmd_addr == 4'(`SHN_ADR_CH_BASE + c * `SHN_ADR_CH_STRIDE + `SHN_OFS_HIGH))
        rd_mux = {8'h00, ofs_q[c][23:16]};
      if (lnk.cmd_addr == 4'(`SHN_ADR_CH_BASE + c * `SHN_ADR_CH_STRIDE + `SHN_OFS_LOW))
        rd_mux = ofs_q[c][15:0];
      if (lnk.cmd_addr == 4'(`SHN_ADR_CH_BASE + c * `SHN_ADR_CH_STRIDE + `SHN_GAIN))
        rd_mux = gain_q[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel filter and calibration
  logic [1:0] res_stb;
  shn_code_t res [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam logic [3:0] BASE = 4'(`SHN_ADR_CH_BASE + c * `SHN_ADR_CH_STRIDE);
    logic signed [AW-1:0] i1_q, i2_q, i3_q, z1_q, z2_q, z3_q;
    logic signed [AW-1:0] y1, y2, y3;
    logic [12:0] dec_q;
    logic [2:0] ratio_seen_q;
    logic dec_hit;
    logic conv_stb_q, diff_stb_q, res_stb_q;
    logic signed [24:0] conv_q;
    logic signed [25:0] diff_q;
    logic signed [43:0] prod;
    shn_code_t res_q;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        ofs_q[c] <= `SHN_OFS_RST;
        gain_q[c] <= `SHN_GAIN_RST;
      end else if (cmd_take && lnk.cmd_write) begin
        if (lnk.cmd_addr == BASE + 4'(`SHN_OFS_HIGH))
          ofs_q[c][23:16] <= lnk.cmd_wdata[7:0];
        if (lnk.cmd_addr == BASE + 4'(`SHN_OFS_LOW))
          ofs_q[c][15:0] <= lnk.cmd_wdata;
        if (lnk.cmd_addr == BASE + 4'(`SHN_GAIN))
          gain_q[c] <= lnk.cmd_wdata;
      end
    end

    // integrators wrap modulo 2^AW; the combs undo it exactly
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        i1_q <= '0;
        i2_q <= '0;
        i3_q <= '0;
      end else if (mod_ph_q) begin
        i1_q <= i1_q + (mod_bit_i[c] ? AW'(1) : -AW'(1));
        i2_q <= i2_q + i1_q;
        i3_q <= i3_q + i2_q;
      end
    end

    assign dec_hit = mod_ph_q && dec_q == ratio_last(ratio_q[c]);
    assign y1 = i3_q - z1_q;
    assign y2 = y1 - z2_q;
    assign y3 = y2 - z3_q;

    // a ratio change restarts the decimation count
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        dec_q <= '0;
        ratio_seen_q <= `SHN_RATIO_RST;
      end else begin
        ratio_seen_q <= ratio_q[c];
        if (ratio_seen_q != ratio_q[c] || dec_hit) dec_q <= '0;
        else if (mod_ph_q) dec_q <= dec_q + 13'h1;
      end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        z1_q <= '0;
        z2_q <= '0;
        z3_q <= '0;
        conv_q <= '0;
        conv_stb_q <= 1'b0;
      end else begin
        conv_stb_q <= dec_hit;
        if (dec_hit) begin
          z1_q <= i3_q;
          z2_q <= y1;
          z3_q <= y2;
          conv_q <= norm(y3, ratio_q[c]);
        end
      end
    end

    assign prod = diff_q * $signed(`SHN_GAIN_ONE + {{2{gain_q[c][15]}}, gain_q[c]});

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        diff_q <= '0;
        diff_stb_q <= 1'b0;
        res_q <= '0;
        res_stb_q <= 1'b0;
      end else begin
        diff_stb_q <= conv_stb_q;
        res_stb_q <= diff_stb_q;
        if (conv_stb_q) diff_q <= 26'(conv_q) - 26'($signed(ofs_q[c]));
        if (diff_stb_q) res_q <= sat24(28'((prod + `SHN_ROUND_HALF) >>> 16));
      end
    end
    assign res[c] = res_q;
    assign res_stb[c] = res_stb_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // result words: latest of both channels, pushed when either updates
  logic [47:0] pend_q;
  logic pend_q_v;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [47:0] fifo_out;
  logic load;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_q <= '0;
      pend_q_v <= 1'b0;
      overrun_o <= 1'b0;
    end else begin
      overrun_o <= |res_stb && pend_q_v && !fifo_in_ready;
      if (res_stb[0]) pend_q[23:0] <= res[0];
      if (res_stb[1]) pend_q[47:24] <= res[1];
      if (|res_stb) pend_q_v <= 1'b1;
      else if (fifo_in_ready) pend_q_v <= 1'b0;
    end
  end

  shn_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(pend_q_v),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pend_q),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame output: a pending register read takes the frame
  logic frm_v_q;
  logic frm_reg_q;
  logic [47:0] frm_data_q;
  assign load = !frm_v_q || lnk.frm_ready;
  assign fifo_out_ready = load && !rd_pend_q;
  assign lnk.frm_valid = frm_v_q;
  assign lnk.frm_reg = frm_reg_q;
  assign lnk.frm_data = frm_data_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_pend_q <= 1'b0;
      rd_data_q <= '0;
    end else if (cmd_take && !lnk.cmd_write) begin
      rd_pend_q <= 1'b1;
      rd_data_q <= rd_mux;
    end else if (load) begin
      rd_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frm_v_q <= 1'b0;
      frm_reg_q <= 1'b0;
      frm_data_q <= '0;
    end else if (load) begin
      frm_v_q <= rd_pend_q || fifo_out_valid;
      frm_reg_q <= rd_pend_q;
      frm_data_q <= rd_pend_q ? {32'h00000000, rd_data_q} : fifo_out;
    end
  end
endmodule : shn_dev

// ===== rtl/shn_host.sv
// host end: coefficient restore, user commands, frame unpacking, averaging
`timescale 1ns/10ps
`include "shn_defs.svh"
module shn_host import shn_pkg::*; #(
  parameter int AVG_LOG = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // stored coefficients
  input wire logic [2:0] nv_ratio_a_i,
  input wire logic [2:0] nv_ratio_b_i,
  input wire logic [23:0] nv_ofs_a_i,
  input wire logic [23:0] nv_ofs_b_i,
  input wire logic [15:0] nv_gain_a_i,
  input wire logic [15:0] nv_gain_b_i,
  input wire logic cal_clear_i,
  output logic busy_o,
  // user register commands
  input wire logic ucmd_valid_i,
  output logic ucmd_ready_o,
  input wire logic ucmd_write_i,
  input wire logic [3:0] ucmd_addr_i,
  input wire logic [15:0] ucmd_wdata_i,
  // results
  input wire logic accept_i,
  output shn_code_t conv_a_o,
  output shn_code_t conv_b_o,
  output logic conv_stb_o,
  output logic [15:0] rd_data_o,
  output logic rd_stb_o,
  output shn_code_t avg_a_o,
  output shn_code_t avg_b_o,
  output logic avg_stb_o,
  // link to device
  shn_link_if.host lnk
);
  if (AVG_LOG < 1 || AVG_LOG > 8) begin : g_bad_avg
    $error("AVG_LOG out of range");
  end

  shn_host_st_t st_q;
  logic [2:0] idx_q;
  logic clr_q;
  logic [15:0] seq_data;
  logic seq_take;

  always_comb begin
    case (idx_q)
      3'h0: seq_data = {9'h000, nv_ratio_b_i, 1'b0, nv_ratio_a_i};
      3'h1: seq_data = clr_q ? 16'h0000 : {8'h00, nv_ofs_a_i[23:16]};
      3'h2: seq_data = clr_q ? 16'h0000 : nv_ofs_a_i[15:0];
      3'h3: seq_data = clr_q ? 16'h0000 : nv_gain_a_i;
      3'h4: seq_data = clr_q ? 16'h0000 : {8'h00, nv_ofs_b_i[23:16]};
      3'h5: seq_data = clr_q ? 16'h0000 : nv_ofs_b_i[15:0];
      default: seq_data = clr_q ? 16'h0000 : nv_gain_b_i;
    endcase
  end

  assign busy_o = st_q == HS_SEQ;
  assign ucmd_ready_o = !busy_o && lnk.cmd_ready;
  assign lnk.cmd_valid = busy_o || ucmd_valid_i;
  assign lnk.cmd_write = busy_o || ucmd_write_i;
  assign lnk.cmd_addr = busy_o ? {1'b0, idx_q} : ucmd_addr_i;
  assign lnk.cmd_wdata = busy_o ? seq_data : ucmd_wdata_i;
  assign seq_take = busy_o && lnk.cmd_ready;

  // reset starts a full restore since the device forgets its coefficients
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= HS_SEQ;
      idx_q <= '0;
      clr_q <= 1'b0;
    end else begin
      case (st_q)
        HS_IDLE: begin
          if (cal_clear_i) begin
            st_q <= HS_SEQ;
            idx_q <= 3'h1;
            clr_q <= 1'b1;
          end
        end
        HS_SEQ: begin
          if (seq_take) begin
            if (idx_q == 3'(`SHN_N_REGS - 1)) st_q <= HS_IDLE;
            else idx_q <= idx_q + 3'h1;
          end
        end
        default: st_q <= HS_IDLE;
      endcase
      if (st_q == HS_IDLE && !cal_clear_i) begin
        idx_q <= '0;
        clr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame unpacking
  logic frm_take;
  assign lnk.frm_ready = accept_i;
  assign frm_take = lnk.frm_valid && accept_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_a_o <= '0;
      conv_b_o <= '0;
      conv_stb_o <= 1'b0;
      rd_data_o <= '0;
      rd_stb_o <= 1'b0;
    end else begin
      conv_stb_o <= frm_take && !lnk.frm_reg;
      rd_stb_o <= frm_take && lnk.frm_reg;
      if (frm_take && lnk.frm_reg) rd_data_o <= lnk.frm_data[15:0];
      if (frm_take && !lnk.frm_reg) begin
        conv_a_o <= lnk.frm_data[23:0];
        conv_b_o <= lnk.frm_data[47:24];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block averages of 2^AVG_LOG results, for offset and gain estimation
  logic signed [31:0] acc_q [2];
  logic [7:0] cnt_q;
  logic last;
  assign last = cnt_q == 8'((1 << AVG_LOG) - 1);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_q[0] <= '0;
      acc_q[1] <= '0;
      cnt_q <= '0;
      avg_a_o <= '0;
      avg_b_o <= '0;
      avg_stb_o <= 1'b0;
    end else begin
      avg_stb_o <= 1'b0;
      if (conv_stb_o) begin
        if (last) begin
          avg_a_o <= 24'((acc_q[0] + 32'(conv_a_o)) >>> AVG_LOG);
          avg_b_o <= 24'((acc_q[1] + 32'(conv_b_o)) >>> AVG_LOG);
          avg_stb_o <= 1'b1;
          acc_q[0] <= '0;
          acc_q[1] <= '0;
          cnt_q <= '0;
        end else begin
          acc_q[0] <= acc_q[0] + 32'(conv_a_o);
          acc_q[1] <= acc_q[1] + 32'(conv_b_o);
          cnt_q <= cnt_q + 8'h1;
        end
      end
    end
  end
endmodule : shn_host

// ===== test/shn_link_properties.sv
// link checker: handshake, frame and restore properties
`timescale 1ns/10ps
module shn_link_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // command channel
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [3:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  // frame channel
  input wire logic frm_valid,
  input wire logic frm_ready,
  input wire logic frm_reg,
  input wire logic [47:0] frm_data
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  //////////////////////////////////////////////////////////////////////////////
  logic rd_take;
  logic rd_done;
  logic [3:0] rd_addr_q;
  logic [1:0] pend_q;
  assign rd_take = cmd_valid && cmd_ready && !cmd_write;
  assign rd_done = frm_valid && frm_ready && frm_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_addr_q <= 4'h0;
    end else if (rd_take) begin
      rd_addr_q <= cmd_addr;
    end
  end
  // exceeds one only if a second read slips past the refusal
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_q <= 2'h0;
    end else begin
      pend_q <= pend_q + {1'b0, rd_take} - {1'b0, rd_done};
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence s_read_take;
    cmd_valid && cmd_ready && !cmd_write;
  endsequence
  sequence s_read_frame;
    frm_valid && frm_reg;
  endsequence
  sequence s_restore;
    (cmd_valid && cmd_write && cmd_addr == 4'h0) ##1 (cmd_valid && cmd_write)[*6];
  endsequence
  a_restore_writes: assert property ($fell(sys_rst_i) |-> s_restore)
    else $error("coefficient restore not issued after reset");
  a_read_answered: assert property (s_read_take |-> ##[1:64] s_read_frame)
    else $error("read not answered in time");
  a_frame_stable: assert property (frm_valid && !frm_ready |=>
    $stable(frm_data) && $stable(frm_reg))
    else $error("frame changed while stalled");
  a_valid_held: assert property ($fell(frm_valid) |-> $past(frm_ready))
    else $error("frame dropped without acceptance");
  a_read_upper_zero: assert property (s_read_frame |-> frm_data[47:16] == 32'h0)
    else $error("read frame upper bits not zero");
  a_unmapped_zero: assert property ((s_read_frame and (rd_addr_q > 4'h6)) |->
    frm_data[15:0] == 16'h0)
    else $error("unmapped read not zero");
  a_one_outstanding: assert property (pend_q <= 2'h1)
    else $error("more than one read outstanding");
  a_cmd_held: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_addr) && $stable(cmd_write) && $stable(cmd_wdata))
    else $error("command changed before acceptance");
endmodule : shn_link_properties

// ===== test/testbench.sv
// bench: both link ends, checker, random calibration and rate scenarios
`timescale 1ns/10ps
module testbench;
  import shn_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] mod_bit_i = 2'h1;
  logic [2:0] nv_ratio_a_i = 3'h0;
  logic [2:0] nv_ratio_b_i = 3'h0;
  logic [23:0] nv_ofs_a_i = 24'h000000;
  logic [23:0] nv_ofs_b_i = 24'h000000;
  logic [15:0] nv_gain_a_i = 16'h0000;
  logic [15:0] nv_gain_b_i = 16'h0000;
  logic cal_clear_i = 1'b0;
  logic ucmd_valid_i = 1'b0;
  logic ucmd_write_i = 1'b0;
  logic [3:0] ucmd_addr_i = 4'h0;
  logic [15:0] ucmd_wdata_i = 16'h0000;
  logic accept_i = 1'b1;
  logic mod_clk_o, mod_en_o, overrun_o, busy_o, ucmd_ready_o;
  logic conv_stb_o, rd_stb_o, avg_stb_o;
  logic [15:0] rd_data_o;
  shn_code_t conv_a_o, conv_b_o, avg_a_o, avg_b_o;
  int miscompares = 0;
  int num_checks = 0;
  always #2 clk_i = ~clk_i;
  //////////////////////////////////////////////////////////////////////////////
  shn_link_if lnk_if ();
  shn_dev #(.FIFO_DEPTH(4)) u_shn_dev (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .mod_bit_i(mod_bit_i), .mod_clk_o(mod_clk_o), .mod_en_o(mod_en_o),
    .overrun_o(overrun_o), .lnk(lnk_if.dev));
  shn_host #(.AVG_LOG(1)) u_shn_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .nv_ratio_a_i(nv_ratio_a_i), .nv_ratio_b_i(nv_ratio_b_i), .nv_ofs_a_i(nv_ofs_a_i),
    .nv_ofs_b_i(nv_ofs_b_i), .nv_gain_a_i(nv_gain_a_i), .nv_gain_b_i(nv_gain_b_i),
    .cal_clear_i(cal_clear_i), .busy_o(busy_o), .ucmd_valid_i(ucmd_valid_i),
    .ucmd_ready_o(ucmd_ready_o), .ucmd_write_i(ucmd_write_i), .ucmd_addr_i(ucmd_addr_i),
    .ucmd_wdata_i(ucmd_wdata_i), .accept_i(accept_i), .conv_a_o(conv_a_o),
    .conv_b_o(conv_b_o), .conv_stb_o(conv_stb_o), .rd_data_o(rd_data_o),
    .rd_stb_o(rd_stb_o), .avg_a_o(avg_a_o), .avg_b_o(avg_b_o), .avg_stb_o(avg_stb_o),
    .lnk(lnk_if.host));
  shn_link_properties u_shn_link_properties (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cmd_valid(lnk_if.cmd_valid), .cmd_ready(lnk_if.cmd_ready),
    .cmd_write(lnk_if.cmd_write), .cmd_addr(lnk_if.cmd_addr),
    .cmd_wdata(lnk_if.cmd_wdata), .frm_valid(lnk_if.frm_valid),
    .frm_ready(lnk_if.frm_ready), .frm_reg(lnk_if.frm_reg), .frm_data(lnk_if.frm_data));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic close_out;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_code(input shn_code_t got, input shn_code_t exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_code
  // rounding half up, then clip to the two full-scale codes
  function automatic shn_code_t cal_exp(input shn_code_t x, input logic [23:0] o,
                                       input logic [15:0] g);
    longint p;
    longint xl;
    // an all-ones stream peaks one code above the top code until the final clip
    xl = (x == 24'h7FFFFF) ? (longint'(1) <<< 23) : longint'(x);
    p = (xl - longint'($signed(o))) * (longint'(65536) + longint'($signed(g)));
    p = (p + 32768) >>> 16;
    if (p > longint'(24'h7FFFFF)) return 24'h7FFFFF;
    if (p < -longint'(24'h800000)) return 24'h800000;
    return shn_code_t'(p[23:0]);
  endfunction : cal_exp
  task automatic wait_hi(input int w, output int n);
    n = 0;
    while ((w == 0 ? conv_stb_o : w == 1 ? rd_stb_o : avg_stb_o) !== 1'b1 && n < 20000) begin
      tick;
      n++;
    end
    if (n >= 20000) chk_val(32'h0, 32'h1);
  endtask : wait_hi
  task automatic ucmd(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    ucmd_valid_i = 1'b1;
    ucmd_write_i = w;
    ucmd_addr_i = a;
    ucmd_wdata_i = d;
    n = 0;
    while (ucmd_ready_o !== 1'b1 && n < 2000) begin
      tick;
      n++;
    end
    tick;
    ucmd_valid_i = 1'b0;
    tick;
  endtask : ucmd
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    int n;
    ucmd(1'b0, a, 16'h0000);
    wait_hi(1, n);
    chk_val({16'h0000, rd_data_o}, {16'h0000, exp});
    tick;
  endtask : rd_chk
  task automatic set_cal(input int c, input logic [23:0] o, input logic [15:0] g);
    ucmd(1'b1, 4'(1 + 3 * c), {8'h00, o[23:16]});
    ucmd(1'b1, 4'(2 + 3 * c), o[15:0]);
    ucmd(1'b1, 4'(3 + 3 * c), g);
  endtask : set_cal
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
  initial begin
    int n;
    logic pm;
    logic seen;
    logic [23:0] oa, ob;
    logic [15:0] ga, gb;
    static logic [23:0] ofs_t [6] = '{24'h000010, 24'hFFFFFF, 24'h000000, 24'h000000,
                               24'h000001, 24'hFFFFF0};
    static logic [15:0] gain_t [6] = '{16'h0000, 16'h0000, 16'h8000, 16'h7FFF, 16'hFFFF,
                                       16'h0001};
    void'($urandom(32'h7BD68F9A));
    nv_ratio_a_i = 3'($urandom);
    nv_ratio_b_i = 3'($urandom);
    nv_ofs_a_i = 24'($urandom);
    nv_ofs_b_i = 24'($urandom);
    nv_gain_a_i = 16'($urandom);
    nv_gain_b_i = 16'($urandom);
    repeat (20) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    n = 0;
    while (busy_o !== 1'b0 && n < 50) begin
      tick;
      n++;
    end
    chk_val(n, 7);
    rd_chk(4'h0, {8'h00, 1'b0, nv_ratio_b_i, 1'b0, nv_ratio_a_i});
    for (int c = 0; c < 2; c++) begin
      oa = c ? nv_ofs_b_i : nv_ofs_a_i;
      ga = c ? nv_gain_b_i : nv_gain_a_i;
      rd_chk(4'(1 + 3 * c), {8'h00, oa[23:16]});
      rd_chk(4'(2 + 3 * c), oa[15:0]);
      rd_chk(4'(3 + 3 * c), ga);
    end
    rd_chk(4'hF, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      pm = mod_clk_o;
      tick;
      chk_val({30'h0, mod_en_o, mod_clk_o}, {30'h0, ~pm, ~pm});
    end
    ucmd(1'b1, 4'h0, 16'h0077);
    rd_chk(4'h0, 16'h0077);
    // ratios 0..4 only: the longest codes would dominate the run time
    for (int c = 0; c < 5; c++) begin
      ucmd(1'b1, 4'h0, {8'h00, 1'b0, 3'(c), 1'b0, 3'(c)});
      repeat (2) begin
        wait_hi(0, n);
        tick;
      end
      wait_hi(0, n);
      chk_val(n + 1, 128 << c);
      tick;
    end
    ucmd(1'b1, 4'h0, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      oa = i < 6 ? ofs_t[i] : 24'($urandom);
      ga = i < 6 ? gain_t[i] : 16'($urandom);
      ob = 24'($urandom);
      gb = 16'($urandom);
      set_cal(0, oa, ga);
      set_cal(1, ob, gb);
      repeat (5) begin
        wait_hi(0, n);
        tick;
      end
      wait_hi(0, n);
      chk_code(conv_a_o, cal_exp(24'h7FFFFF, oa, ga));
      chk_code(conv_b_o, cal_exp(24'h800000, ob, gb));
      tick;
    end
    repeat (2) begin
      wait_hi(2, n);
      tick;
    end
    wait_hi(2, n);
    chk_code(avg_a_o, cal_exp(24'h7FFFFF, oa, ga));
    chk_code(avg_b_o, cal_exp(24'h800000, ob, gb));
    cal_clear_i = 1'b1;
    tick;
    cal_clear_i = 1'b0;
    n = 0;
    while (busy_o !== 1'b0 && n < 50) begin
      tick;
      n++;
    end
    rd_chk(4'h3, 16'h0000);
    rd_chk(4'h4, 16'h0000);
    accept_i = 1'b0;
    seen = 1'b0;
    repeat (1500) begin
      tick;
      if (overrun_o === 1'b1) seen = 1'b1;
    end
    chk_val(seen, 1'b1);
    ucmd(1'b0, 4'h3, 16'h0000);
    fork
      ucmd(1'b1, 4'h3, 16'h1234);
      begin
        repeat (20) tick;
        accept_i = 1'b1;
        wait_hi(1, n);
        chk_val({16'h0000, rd_data_o}, 32'h0);
      end
    join
    rd_chk(4'h3, 16'h1234);
    repeat (10) begin
      wait_hi(0, n);
      tick;
    end
    wait_hi(0, n);
    chk_code(conv_a_o, cal_exp(24'h7FFFFF, 24'h000000, 16'h1234));
    close_out();
  end
endmodule : testbench
